// >>> pkg/jtap_consts.svh
// Constants of the test access port: instruction codes, reset values and widths.
// Assumes inclusion by bare name from the package and the design files.
`ifndef JTAP_CONSTS_SVH
`define JTAP_CONSTS_SVH

// =====================================================================
// Instruction chain
`define JTAP_IR_W        4
`define JTAP_IR_EXTEST   4'h0
`define JTAP_IR_INTEST   4'h1
`define JTAP_IR_SAMPLE   4'h2
`define JTAP_IR_STREAM   4'h4
`define JTAP_IR_IDCODE   4'hE
`define JTAP_IR_BYPASS   4'hF
`define JTAP_IR_CAPTURE  4'h1

// =====================================================================
// Data chains
`define JTAP_ID_W        32
// Identification value is arbitrary.
`define JTAP_ID_DEFAULT  32'h1234_5001
`define JTAP_BSR_W       8
`define JTAP_STRM_W      8
`define JTAP_STRM_D      16

// =====================================================================
// Mode-select reset sequence length
`define JTAP_TMS_RST_N   3'h5
`define JTAP_TMS_CNT_W   3

`endif

// >>> pkg/jtap_pkg.sv
// Types of the test access port: controller states and data chain selection.
// Assumes the constants header is on the include path.
package jtap_pkg;
`include "jtap_consts.svh"

   // ==================================================================
   // Controller states, one-hot
   typedef enum logic [15:0] {
      JTAP_TLR    = 16'h0001,
      JTAP_RTI    = 16'h0002,
      JTAP_SEL_DR = 16'h0004,
      JTAP_CAP_DR = 16'h0008,
      JTAP_SHF_DR = 16'h0010,
      JTAP_EX1_DR = 16'h0020,
      JTAP_PAU_DR = 16'h0040,
      JTAP_EX2_DR = 16'h0080,
      JTAP_UPD_DR = 16'h0100,
      JTAP_SEL_IR = 16'h0200,
      JTAP_CAP_IR = 16'h0400,
      JTAP_SHF_IR = 16'h0800,
      JTAP_EX1_IR = 16'h1000,
      JTAP_PAU_IR = 16'h2000,
      JTAP_EX2_IR = 16'h4000,
      JTAP_UPD_IR = 16'h8000
   } jtap_state_t;

   // ==================================================================
   // Data chain chosen by the current instruction
   typedef enum logic [4:0] {
      JTAP_CH_NONE = 5'h01,
      JTAP_CH_BYP  = 5'h02,
      JTAP_CH_ID   = 5'h04,
      JTAP_CH_BS   = 5'h08,
      JTAP_CH_STRM = 5'h10
   } jtap_chain_t;
endpackage

// >>> verilog/jtap_fifo.sv
// Synchronous FIFO carrying words shifted in through the stream chain.
// Assumes one clock and a synchronised active-low reset; DEPTH is a power of two.
`timescale 1ns/10ps
`include "jtap_consts.svh"
module jtap_fifo #(
   parameter int WIDTH = `JTAP_STRM_W,
   parameter int DEPTH = `JTAP_STRM_D
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   import jtap_pkg::*;
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    wr_ptr_nxt;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW-1:0]    rd_ptr_nxt;
   logic [AW:0]      cnt_r;
   logic [AW:0]      cnt_nxt;
   logic             push;
   logic             pop;

   // =================================================================
   // Pointer and level logic
   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      cnt_nxt    = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         cnt_r    <= cnt_nxt;
      end
   end

   // Storage has no reset; only written words are ever read.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end
endmodule

// >>> verilog/jtap_top.sv
// Test access port controller with instruction, bypass, identification,
// boundary and stream chains, sampled from the system clock.
// Assumes test pins arrive asynchronously and test clock is well below clk/4.
//
// How it works
// - State advances only at sampled test-clock rising edges, chosen by mode-select.
// - Test reset low forces and holds Test-Logic-Reset.
// - Entering Test-Logic-Reset loads the identification instruction.
// - Five rising edges with mode-select high always reach Test-Logic-Reset.
// - Power-on reset also puts the controller into Test-Logic-Reset.
// - A static test clock leaves state and all chains untouched.
// - Unimplemented instruction codes behave as bypass.
// - External and internal test instructions touch no chain.
// - The held instruction chooses which data chain is captured, shifted, updated.
// - Controller state chooses instruction or data chain and capture, shift, update.
// - Data-in is sampled at each rising edge in Shift-IR or Shift-DR into the chosen chain.
// - Data-out is released at each falling edge outside shifting, and after reset.
// - Capture loads a chain in parallel; shift moves one bit per edge.
// - Update copies the chain into its holding register, else unchanged.
// - After reset the shared pins serve the test port; select bit reassigns them.
// - Instruction chain and instruction register are four bits wide.
// - Code 1111 picks one-bit bypass; code 1110 picks identification chain.
`timescale 1ns/10ps
`include "jtap_consts.svh"
module jtap_top #(
   parameter int          BSR_W    = `JTAP_BSR_W,
   parameter int          STRM_W   = `JTAP_STRM_W,
   parameter int          STRM_D   = `JTAP_STRM_D,
   parameter logic [31:0] ID_VALUE = `JTAP_ID_DEFAULT
) (
   // System clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // Test port pins
   input  wire logic              tck,
   input  wire logic              tms,
   input  wire logic              tdi,
   input  wire logic              trst_n,
   output logic                   tdo,
   output logic                   tdo_oe_n,
   // Pin function selection
   input  wire logic              fn_sel_wr,
   input  wire logic              alternate_function_bit,
   output logic                   pin_alternate_function_select,
   // Boundary cells
   input  wire logic [BSR_W-1:0]  bs_pin_in,
   output logic [BSR_W-1:0]       bs_drive,
   output logic                   bs_ext_en,
   output logic                   bs_int_en,
   // Stream output
   output logic                   strm_valid,
   output logic [STRM_W-1:0]      strm_data,
   input  wire logic              strm_ready,
   // Controller state
   output jtap_pkg::jtap_state_t  tap_state
);
   import jtap_pkg::*;

   logic               rst_s1;
   logic               rst_n;
   logic               tck_s1, tck_s2, tck_s3;
   logic               tms_s1, tms_s2;
   logic               tdi_s1, tdi_s2;
   logic               trst_s1, trst_s2;
   logic [BSR_W-1:0]   bsi_s1, bsi_s2;
   logic               tck_rise;
   logic               tck_fall;
   jtap_state_t        state_r, state_nxt;
   logic [3:0]         ir_sr_r, ir_sr_nxt, ir_r, ir_nxt;
   logic               byp_r, byp_nxt;
   logic [31:0]        id_sr_r, id_sr_nxt;
   logic [BSR_W-1:0]   bs_sr_r, bs_sr_nxt, bs_hold_r, bs_hold_nxt;
   logic [STRM_W-1:0]  us_sr_r, us_sr_nxt;
   logic               sel_r, sel_nxt, ext_r, ext_nxt, int_r, int_nxt;
   logic               tdo_r, tdo_nxt, oe_n_r, oe_n_nxt;
   logic               sv_r, sv_nxt;
   logic [STRM_W-1:0]  sd_r, sd_nxt;
   jtap_chain_t        chain;
   logic               push, f_in_ready, f_out_valid, f_out_ready;
   logic [STRM_W-1:0]  f_out_data;
   logic               shifting;
   logic               chain_lsb;

   // ==================================================================
   // Reset release and pin synchronisers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {tck_s1, tck_s2, tck_s3} <= 3'h7;
         {tms_s1, tms_s2}         <= 2'h3;
         {tdi_s1, tdi_s2}         <= 2'h3;
         {trst_s1, trst_s2}       <= 2'h0;
         bsi_s1                   <= '0;
         bsi_s2                   <= '0;
      end else begin
         {tck_s1, tck_s2, tck_s3} <= {tck, tck_s1, tck_s2};
         {tms_s1, tms_s2}         <= {tms, tms_s1};
         {tdi_s1, tdi_s2}         <= {tdi, tdi_s1};
         {trst_s1, trst_s2}       <= {trst_n, trst_s1};
         bsi_s1                   <= bs_pin_in;
         bsi_s2                   <= bsi_s1;
      end
   end

   // Edges count only while the pins serve the test port.
   assign tck_rise = sel_r & tck_s2 & ~tck_s3;
   assign tck_fall = sel_r & ~tck_s2 & tck_s3;

   // ==================================================================
   // Controller state transitions
   function automatic jtap_state_t tap_next(input jtap_state_t s, input logic m);
      case (s)
         JTAP_TLR:    tap_next = m ? JTAP_TLR    : JTAP_RTI;
         JTAP_RTI:    tap_next = m ? JTAP_SEL_DR : JTAP_RTI;
         JTAP_SEL_DR: tap_next = m ? JTAP_SEL_IR : JTAP_CAP_DR;
         JTAP_CAP_DR: tap_next = m ? JTAP_EX1_DR : JTAP_SHF_DR;
         JTAP_SHF_DR: tap_next = m ? JTAP_EX1_DR : JTAP_SHF_DR;
         JTAP_EX1_DR: tap_next = m ? JTAP_UPD_DR : JTAP_PAU_DR;
         JTAP_PAU_DR: tap_next = m ? JTAP_EX2_DR : JTAP_PAU_DR;
         JTAP_EX2_DR: tap_next = m ? JTAP_UPD_DR : JTAP_SHF_DR;
         JTAP_UPD_DR: tap_next = m ? JTAP_SEL_DR : JTAP_RTI;
         JTAP_SEL_IR: tap_next = m ? JTAP_TLR    : JTAP_CAP_IR;
         JTAP_CAP_IR: tap_next = m ? JTAP_EX1_IR : JTAP_SHF_IR;
         JTAP_SHF_IR: tap_next = m ? JTAP_EX1_IR : JTAP_SHF_IR;
         JTAP_EX1_IR: tap_next = m ? JTAP_UPD_IR : JTAP_PAU_IR;
         JTAP_PAU_IR: tap_next = m ? JTAP_EX2_IR : JTAP_PAU_IR;
         JTAP_EX2_IR: tap_next = m ? JTAP_UPD_IR : JTAP_SHF_IR;
         JTAP_UPD_IR: tap_next = m ? JTAP_SEL_DR : JTAP_RTI;
         default:     tap_next = JTAP_TLR;
      endcase
   endfunction

   // Instruction decode into a data chain.
   always_comb begin
      case (ir_r)
         `JTAP_IR_EXTEST: chain = JTAP_CH_NONE;
         `JTAP_IR_INTEST: chain = JTAP_CH_NONE;
         `JTAP_IR_SAMPLE: chain = JTAP_CH_BS;
         `JTAP_IR_STREAM: chain = JTAP_CH_STRM;
         `JTAP_IR_IDCODE: chain = JTAP_CH_ID;
         default:         chain = JTAP_CH_BYP;
      endcase
   end

   assign push = tck_rise & trst_s2 & (state_r == JTAP_UPD_DR) & (chain == JTAP_CH_STRM);

   // ==================================================================
   // Controller state and shift chains
   always_comb begin
      state_nxt   = state_r;
      ir_sr_nxt   = ir_sr_r;
      ir_nxt      = ir_r;
      byp_nxt     = byp_r;
      id_sr_nxt   = id_sr_r;
      bs_sr_nxt   = bs_sr_r;
      bs_hold_nxt = bs_hold_r;
      us_sr_nxt   = us_sr_r;
      sel_nxt     = fn_sel_wr ? alternate_function_bit : sel_r;
      if (!trst_s2) begin
         state_nxt = JTAP_TLR;
      end else if (tck_rise) begin
         state_nxt = tap_next(state_r, tms_s2);
         case (state_r)
            JTAP_CAP_IR: ir_sr_nxt = `JTAP_IR_CAPTURE;
            JTAP_SHF_IR: ir_sr_nxt = {tdi_s2, ir_sr_r[3:1]};
            JTAP_UPD_IR: ir_nxt    = ir_sr_r;
            JTAP_CAP_DR: begin
               byp_nxt   = (chain == JTAP_CH_BYP) ? 1'b0 : byp_r;
               id_sr_nxt = (chain == JTAP_CH_ID) ? ID_VALUE : id_sr_r;
               bs_sr_nxt = (chain == JTAP_CH_BS) ? bsi_s2 : bs_sr_r;
               // The stream chain reports a full buffer in its low bit.
               us_sr_nxt = (chain == JTAP_CH_STRM) ? STRM_W'({~f_in_ready}) : us_sr_r;
            end
            JTAP_SHF_DR: begin
               byp_nxt   = (chain == JTAP_CH_BYP) ? tdi_s2 : byp_r;
               id_sr_nxt = (chain == JTAP_CH_ID) ? {tdi_s2, id_sr_r[31:1]} : id_sr_r;
               bs_sr_nxt = (chain == JTAP_CH_BS) ? {tdi_s2, bs_sr_r[BSR_W-1:1]} : bs_sr_r;
               us_sr_nxt = (chain == JTAP_CH_STRM) ? {tdi_s2, us_sr_r[STRM_W-1:1]}
                                                   : us_sr_r;
            end
            JTAP_UPD_DR: bs_hold_nxt = (chain == JTAP_CH_BS) ? bs_sr_r : bs_hold_r;
            default: ;
         endcase
      end
      if (state_nxt == JTAP_TLR) begin
         ir_nxt = `JTAP_IR_IDCODE;
      end
      ext_nxt = (ir_nxt == `JTAP_IR_EXTEST);
      int_nxt = (ir_nxt == `JTAP_IR_INTEST);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= JTAP_TLR;
         ir_sr_r   <= '0;
         ir_r      <= `JTAP_IR_IDCODE;
         byp_r     <= 1'b0;
         id_sr_r   <= '0;
         bs_sr_r   <= '0;
         bs_hold_r <= '0;
         us_sr_r   <= '0;
         sel_r     <= 1'b1;
         ext_r     <= 1'b0;
         int_r     <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         ir_sr_r   <= ir_sr_nxt;
         ir_r      <= ir_nxt;
         byp_r     <= byp_nxt;
         id_sr_r   <= id_sr_nxt;
         bs_sr_r   <= bs_sr_nxt;
         bs_hold_r <= bs_hold_nxt;
         us_sr_r   <= us_sr_nxt;
         sel_r     <= sel_nxt;
         ext_r     <= ext_nxt;
         int_r     <= int_nxt;
      end
   end

   // ==================================================================
   // Data-out driver, changed only on falling test-clock edges; enable also released while the pins are reassigned
   always_comb begin
      case (chain)
         JTAP_CH_BYP:  chain_lsb = byp_r;
         JTAP_CH_ID:   chain_lsb = id_sr_r[0];
         JTAP_CH_BS:   chain_lsb = bs_sr_r[0];
         JTAP_CH_STRM: chain_lsb = us_sr_r[0];
         default:      chain_lsb = 1'b0;
      endcase
      shifting = (state_r == JTAP_SHF_IR) ||
                 ((state_r == JTAP_SHF_DR) && (chain != JTAP_CH_NONE));
      tdo_nxt  = tdo_r;
      oe_n_nxt = sel_r ? oe_n_r : 1'b1;
      if (tck_fall) begin
         tdo_nxt  = (state_r == JTAP_SHF_IR) ? ir_sr_r[0] : chain_lsb;
         oe_n_nxt = ~shifting;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tdo_r  <= 1'b1;
         oe_n_r <= 1'b1;
      end else begin
         tdo_r  <= tdo_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end

   // ==================================================================
   // Stream buffer and output register
   jtap_fifo #(.WIDTH(STRM_W), .DEPTH(STRM_D)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (f_in_ready),
      .in_data   (us_sr_r),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   assign f_out_ready = f_out_valid & (~sv_r | strm_ready);

   always_comb begin
      sv_nxt = f_out_ready ? 1'b1 : (strm_ready ? 1'b0 : sv_r);
      sd_nxt = f_out_ready ? f_out_data : sd_r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sv_r <= 1'b0;
         sd_r <= '0;
      end else begin
         sv_r <= sv_nxt;
         sd_r <= sd_nxt;
      end
   end

   assign tdo                           = tdo_r;
   assign tdo_oe_n                      = oe_n_r;
   assign pin_alternate_function_select = sel_r;
   assign bs_drive                      = bs_hold_r;
   assign bs_ext_en                     = ext_r;
   assign bs_int_en                     = int_r;
   assign strm_valid                    = sv_r;
   assign strm_data                     = sd_r;
   assign tap_state                     = state_r;

   // ==================================================================
   // Checks
   logic [2:0] tms_cnt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tms_cnt_r <= '0;
      end else if (tck_rise) begin
         tms_cnt_r <= !tms_s2 ? 3'h0 : (tms_cnt_r == `JTAP_TMS_RST_N) ? tms_cnt_r
                                                               : tms_cnt_r + 3'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_trst; !trst_s2 |=> state_r == JTAP_TLR; endproperty
   a_trst: assert property (p_trst) else $error("test reset did not force reset state");
   property p_tms5; tck_rise && tms_s2 && tms_cnt_r == 3'h4 |=> state_r == JTAP_TLR;
   endproperty
   a_tms5: assert property (p_tms5) else $error("five high mode bits missed reset");
   property p_idc; state_r == JTAP_TLR |=> ir_r == `JTAP_IR_IDCODE; endproperty
   a_idc: assert property (p_idc) else $error("reset state did not load id instruction");
   property p_static; !tck_rise && trst_s2 |=> $stable(state_r) && $stable(ir_r)
      && $stable(id_sr_r) && $stable(bs_hold_r); endproperty
   a_static: assert property (p_static) else $error("state moved without clock edge");
   property p_tdo; !tck_fall |=> $stable(tdo_r); endproperty
   a_tdo: assert property (p_tdo) else $error("data-out changed off a falling edge");
   property p_tdoz; tck_fall && !shifting |=> oe_n_r ##1 oe_n_r || tck_fall; endproperty
   a_tdoz: assert property (p_tdoz) else $error("data-out driven while idle");
   property p_updir; tck_rise && trst_s2 && state_r == JTAP_UPD_IR |=> ir_r == $past(ir_sr_r);
   endproperty
   a_updir: assert property (p_updir) else $error("instruction update lost");
   property p_ext; ir_r == `JTAP_IR_EXTEST |=> $stable(bs_sr_r) && $stable(bs_hold_r);
   endproperty
   a_ext: assert property (p_ext) else $error("boundary chain touched by extest");
   property p_capid; tck_rise && trst_s2 && state_r == JTAP_CAP_DR && chain == JTAP_CH_ID
      |=> id_sr_r == ID_VALUE; endproperty
   a_capid: assert property (p_capid) else $error("id chain capture wrong");
   property p_byp; ir_r != `JTAP_IR_EXTEST && ir_r != `JTAP_IR_INTEST && ir_r != `JTAP_IR_SAMPLE
      && ir_r != `JTAP_IR_STREAM && ir_r != `JTAP_IR_IDCODE |-> chain == JTAP_CH_BYP; endproperty
   a_byp: assert property (p_byp) else $error("unused code not bypass");

   property p_cov_ir; tck_rise && state_r == JTAP_UPD_IR; endproperty
   c_cov_ir: cover property (p_cov_ir);
   property p_cov_push; push && f_in_ready; endproperty
   c_cov_push: cover property (p_cov_push);
   property p_cov_full; push && !f_in_ready; endproperty
   c_cov_full: cover property (p_cov_full);
endmodule

// >>> bench/jtap_probe.sv
// Behavioural boundary-scan tester that drives the test pins of the port.
// Assumes data-out arrives already resolved, pulled up while released.
`timescale 1ns/10ps
module jtap_probe #(
   parameter int HALF = 80
) (
   // Test port pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst_n,
   input  wire logic tdo_line
);
   // ===========================================================
   // Idle levels match the pull-ups, so the clock stands still high.
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b1;
   end

   // ===========================================================
   // One test clock period; data-out is read just before the rise.
   task automatic step(input logic m, input logic b, output logic q);
      tck = 1'b0;
      tms = m;
      tdi = b;
      #(HALF);
      q = tdo_line;
      tck = 1'b1;
      #(HALF);
   endtask

   task automatic walk(input logic [7:0] seq, input int n);
      logic q;
      for (int i = 0; i < n; i++) step(seq[i], 1'b1, q);
   endtask

   // Full scan from idle back to idle, bits LSB first.
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = 32'h0;
      if (ir) walk(8'h03, 4);
      else walk(8'h01, 3);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      walk(8'h01, 2);
   endtask

   task automatic park_low;
      tck = 1'b0;
   endtask

   task automatic set_trst(input logic v);
      trst_n = v;
   endtask
endmodule

// >>> bench/jtap_top_bench.sv
// Self-checking bench of the test access port, driven through the probe model.
// Assumes the probe owns the test pins and data-out has a pull-up.
`timescale 1ns/10ps
`include "jtap_consts.svh"
module jtap_top_bench;
   import jtap_pkg::*;
   logic        clk, arst_n, fn_sel_wr, alt_bit, strm_ready;
   logic [7:0]  pin_in;
   logic [31:0] d;
   wire         tck, tms, tdi, trst_n, tdo, tdo_oe_n, sel, ext_en, int_en, strm_valid;
   wire  [7:0]  drive, strm_data;
   jtap_state_t st;
   int          err_total, samples_checked, cyc;
   wire         tdo_line = tdo_oe_n ? 1'b1 : tdo;

   jtap_top u_dut (.clk(clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .fn_sel_wr(fn_sel_wr),
      .alternate_function_bit(alt_bit), .pin_alternate_function_select(sel),
      .bs_pin_in(pin_in), .bs_drive(drive), .bs_ext_en(ext_en), .bs_int_en(int_en),
      .strm_valid(strm_valid), .strm_data(strm_data), .strm_ready(strm_ready),
      .tap_state(st));
   jtap_probe u_probe (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo_line(tdo_line));

   // ===========================================================
   // Clock, watchdog and reporting
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("Checks %0d, errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ===========================================================
   // Scenarios
   task automatic t_id;
      u_probe.walk(8'h00, 1);
      u_probe.scan(1'b0, 32, 32'h0, d);
      chk("idcode", d, `JTAP_ID_DEFAULT);
      chk("idle", st, JTAP_RTI);
   endtask

   task automatic t_bypass;
      logic [3:0] codes [6] = '{4'hF, 4'h8, 4'hA, 4'hB, 4'h3, 4'h5};
      foreach (codes[i]) begin
         u_probe.scan(1'b1, 4, {28'h0, codes[i]}, d);
         chk("ir capture", d[3:0], 4'h1);
         u_probe.scan(1'b0, 8, 32'hA5, d);
         chk("bypass", d[7:0], 8'h4A);
      end
   endtask

   task automatic t_bound;
      pin_in = 8'hC3;
      u_probe.scan(1'b1, 4, 32'h2, d);
      u_probe.scan(1'b0, 8, 32'h5A, d);
      chk("sample", d[7:0], 8'hC3);
      chk("drive", drive, 8'h5A);
      u_probe.scan(1'b1, 4, 32'h0, d);
      chk("ext", ext_en, 1'b1);
      u_probe.scan(1'b0, 8, 32'h0, d);
      chk("ext out", d[7:0], 8'hFF);
      chk("ext drive", drive, 8'h5A);
      u_probe.scan(1'b1, 4, 32'h1, d);
      chk("int", int_en, 1'b1);
   endtask

   task automatic t_five;
      u_probe.walk(8'h03, 4);
      u_probe.walk(8'h01, 1);
      chk("oe shifting", tdo_oe_n, 1'b0);
      u_probe.walk(8'h0F, 4);
      chk("five", st, JTAP_TLR);
      chk("oe idle", tdo_oe_n, 1'b1);
      t_id();
   endtask

   task automatic t_trst;
      u_probe.scan(1'b1, 4, 32'hF, d);
      u_probe.set_trst(1'b0);
      repeat (6) tick();
      chk("trst", st, JTAP_TLR);
      u_probe.walk(8'h00, 1);
      chk("trst held", st, JTAP_TLR);
      u_probe.set_trst(1'b1);
      repeat (6) tick();
      t_id();
   endtask

   task automatic t_static;
      u_probe.walk(8'h01, 1);
      repeat (200) tick();
      chk("static high", st, JTAP_SEL_DR);
      u_probe.park_low();
      repeat (200) tick();
      chk("static low", st, JTAP_SEL_DR);
      u_probe.walk(8'h06, 4);
      chk("drive kept", drive, 8'h5A);
   endtask

   task automatic t_stream;
      int n;
      n = 0;
      u_probe.scan(1'b1, 4, 32'h4, d);
      // Sixteen buffered words plus the output register: the eighteenth word is refused.
      for (int i = 0; i < 18; i++) begin
         u_probe.scan(1'b0, 8, 32'h10 + i, d);
         chk("full", d[0], i == 17);
      end
      for (int k = 0; k < 100 && n < 17; k++) begin
         tick();
         if (strm_valid === 1'b1) begin
            chk("word", strm_data, 8'h10 + n);
            n++;
         end
         strm_ready = 1'b1;
      end
      chk("count", n, 17);
      repeat (3) tick();
      chk("drained", strm_valid, 1'b0);
      strm_ready = 1'b0;
   endtask

   task automatic t_pin_sel(input logic v);
      tick();
      fn_sel_wr = 1'b1;
      alt_bit = v;
      tick();
      fn_sel_wr = 1'b0;
      tick();
      chk("select", sel, v);
   endtask

   // ===========================================================
   // Main sequence
   initial begin
      arst_n = 1'b0;
      fn_sel_wr = 1'b0;
      alt_bit = 1'b1;
      strm_ready = 1'b0;
      pin_in = 8'h00;
      cyc = 0;
      repeat (20) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (6) tick();
      chk("reset state", st, JTAP_TLR);
      chk("reset oe", tdo_oe_n, 1'b1);
      chk("reset select", sel, 1'b1);
      t_id();
      t_bypass();
      t_bound();
      t_five();
      t_trst();
      t_static();
      t_stream();
      t_pin_sel(1'b0);
      u_probe.walk(8'h01, 1);
      chk("ignored", st, JTAP_RTI);
      t_pin_sel(1'b1);
      stop_test();
   end
endmodule
